//--- entry_match_pkg.sv
// shared constants, encodings and carriers of the filter_entry port/flag matcher
// assumes: 32-bit AXI4-Lite register bus, single clock domain
package entry_match_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ctrl_off     = 8'h00;  // selectors and protocol
  localparam logic [7:0] flags_off    = 8'h04;  // six two-bit flag settings
  localparam logic [7:0] src_val_off  = 8'h08;  // source value / range low+high
  localparam logic [7:0] dst_val_off  = 8'h0C;
  localparam logic [7:0] status_off   = 8'h10;  // match result and counters
  localparam logic [7:0] hits_off     = 8'h14;
  localparam logic [7:0] frames_off   = 8'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int src_sel_lsb  = 0;
  localparam int dst_sel_lsb  = 2;
  localparam int proto_lsb    = 4;
  localparam int flag_w       = 2;
  localparam int n_flags      = 6;
  localparam int range_hi_lsb = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] ctrl_rst  = 32'h0000_0000;
  localparam logic [31:0] flags_rst = 32'h0000_0FFF;  // all flags don't-care
  localparam logic [31:0] val_rst   = 32'hFFFF_0000;  // full range

  // ****************************************************************
  // encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    port_any      = 2'b00,
    port_specific = 2'b01,
    port_range    = 2'b10
  } port_sel_t;

  typedef enum logic [1:0] {
    flag_clear = 2'b00,
    flag_set   = 2'b01,
    flag_dont  = 2'b11
  } flag_sel_t;

  typedef enum logic [1:0] {
    proto_off = 2'b00,
    proto_tcp = 2'b01,
    proto_udp = 2'b10,
    proto_both = 2'b11
  } proto_sel_t;

  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // header fields from the ingress parser
  typedef struct packed {
    logic        is_tcp;
    logic        is_udp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [5:0]  tcp_flags;  // {urg,ack,psh,rst,syn,fin}
  } hdr_t;

  // per-port settings carried to the compare unit
  typedef struct packed {
    logic [1:0]  sel;
    logic [15:0] lo;
    logic [15:0] hi;
  } port_cfg_t;

endpackage

//--- port_compare.sv
// one port-condition test: any, exact value or inclusive range
// assumes: purely combinational, settings stable while used
`timescale 1ns/1ps
module port_compare (
  // settings
  input  wire entry_match_pkg::port_cfg_t cfg,
  // frame value and verdict
  input  wire logic [15:0]                port_value,
  output logic                            hit
);

  // inclusive bounds: a port equal to either bound counts as inside
  always_comb begin
    case (cfg.sel)
      entry_match_pkg::port_any:      hit = 1'b1;
      entry_match_pkg::port_specific: hit = (port_value == cfg.lo);
      entry_match_pkg::port_range:    hit = (port_value >= cfg.lo) && (port_value <= cfg.hi);
      default:                        hit = 1'b0;  // reserved selector never matches
    endcase
  end

endmodule

//--- entry_matcher.sv
// tcp/udp port and flag match stage of one filter_entry, with its AXI4-Lite settings
// assumes: parser presents one header per hdr_valid pulse, synchronous to aclk
//
// Function
// RULE1 - source selector any: source port is ignored.
// RULE2 - source selector specific: source port must equal the 16-bit value.
// RULE3 - source selector range: source port must fall within the configured range.
// RULE4 - destination selector any: destination port is ignored.
// RULE5 - destination selector specific: destination port must equal the value.
// RULE6 - destination selector range: destination port must lie in the range.
// RULE7 - fin setting: 0 needs clear, 1 needs set, don't-care ignores.
// RULE8 - syn setting: 0 needs clear, 1 needs set, don't-care ignores.
// RULE9 - rst setting: 0 needs clear, 1 needs set, don't-care ignores.
// RULE10 - psh setting: 0 needs clear, 1 needs set, don't-care ignores.
// RULE11 - ack setting: 0 needs clear, 1 needs set, don't-care ignores.
// RULE12 - urg setting: 0 needs clear, 1 needs set, don't-care ignores.
// RULE13 - conditions apply only to the selected protocol; flags only for tcp.
// RULE14 - entry matches only when every condition holds together.
// RULE15 - range uses low and high bounds, both inclusive.
// RULE16 - flags are two-bit codes; result appears one cycle after the header.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module entry_matcher (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // header from the ingress parser
  input  wire logic                  hdr_valid,
  input  wire entry_match_pkg::hdr_t hdr,
  // match verdict
  output logic                       match_valid,
  output logic                       match_hit
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] flags;
    logic [31:0] src_val;
    logic [31:0] dst_val;
    logic        mvalid;
    logic        mhit;
    logic [31:0] hits;
    logic [31:0] frames;
  } state_t;

  // state_reg holds every flop of the block; state_next is its combinational copy
  state_t state_reg;
  state_t state_next;

  // ****************************************************************
  // register fields
  // ****************************************************************
  // ctrl   [1:0] source selector, [3:2] destination selector, [5:4] protocol
  //        selector codes: 00 any, 01 specific, 10 range, 11 never matches
  //        protocol codes: 00 off, 01 tcp, 10 udp, 11 tcp or udp
  //        unused bits read back as zero
  // flags  two bits per flag from fin at [1:0] up to urg at [11:10]
  //        codes: 00 must be clear, 01 must be set, 11 don't-care, 10 never
  // values [15:0] exact value or range low, [31:16] range high
  //        a low bound above the high bound leaves the range empty
  // status bit0 last verdict, bit1 verdict valid; both live for one cycle only
  // hits, frames: free-running counters, any write to a counter clears both
  //        a frame counted in the clearing cycle still counts, so none is lost

  // ****************************************************************
  // match datapath
  // ****************************************************************
  // per-condition results, combined into one verdict below
  entry_match_pkg::port_cfg_t src_cfg;
  entry_match_pkg::port_cfg_t dst_cfg;
  logic                       src_hit;
  logic                       dst_hit;
  logic [5:0]                 flag_ok;
  logic                       proto_ok;
  logic                       entry_hit;
  logic [1:0]                 proto_sel;

  // a range holds low in the lower half, high in the upper half
  assign src_cfg = '{sel: state_reg.ctrl[entry_match_pkg::src_sel_lsb +: 2],
                     lo:  state_reg.src_val[15:0],
                     hi:  state_reg.src_val[entry_match_pkg::range_hi_lsb +: 16]};  // RULE15
  assign dst_cfg = '{sel: state_reg.ctrl[entry_match_pkg::dst_sel_lsb +: 2],
                     lo:  state_reg.dst_val[15:0],
                     hi:  state_reg.dst_val[entry_match_pkg::range_hi_lsb +: 16]};  // RULE15
  // protocol selector, decoded by the gate below
  assign proto_sel = state_reg.ctrl[entry_match_pkg::proto_lsb +: 2];

  // source: any, exact or range
  port_compare src_cmp (
    .cfg        (src_cfg),
    .port_value (hdr.src_port),
    .hit        (src_hit)  // RULE1 RULE2 RULE3
  );

  // destination: any, exact or range
  port_compare dst_cmp (
    .cfg        (dst_cfg),
    .port_value (hdr.dst_port),
    .hit        (dst_hit)  // RULE4 RULE5 RULE6
  );

  // per-flag test; bit 0 fin .. bit 5 urg, flags only bind tcp frames
  genvar gi;
  generate
    for (gi = 0; gi < entry_match_pkg::n_flags; gi++) begin : g_flag
      logic [1:0] code;
      logic       ok;
      assign code = state_reg.flags[gi*entry_match_pkg::flag_w +: entry_match_pkg::flag_w];
      // a local result keeps each process the only writer of what it assigns
      always_comb begin
        if (!hdr.is_tcp) begin
          ok = 1'b1;  // RULE13
        end else begin
          case (code)
            entry_match_pkg::flag_clear: ok = ~hdr.tcp_flags[gi];  // RULE7 RULE8 RULE9
            entry_match_pkg::flag_set:   ok = hdr.tcp_flags[gi];   // RULE10 RULE11 RULE12
            entry_match_pkg::flag_dont:  ok = 1'b1;               // RULE16
            default:                     ok = 1'b0;  // reserved code never matches
          endcase
        end
      end
      assign flag_ok[gi] = ok;
    end
  endgenerate

  // protocol gate: disabled entry or wrong protocol never matches
  always_comb begin
    case (proto_sel)
      entry_match_pkg::proto_tcp:  proto_ok = hdr.is_tcp;  // RULE13
      entry_match_pkg::proto_udp:  proto_ok = hdr.is_udp;
      entry_match_pkg::proto_both: proto_ok = hdr.is_tcp | hdr.is_udp;
      default:                     proto_ok = 1'b0;
    endcase
  end

  // every test must pass at once; a single failing condition vetoes the entry
  assign entry_hit = proto_ok & src_hit & dst_hit & (&flag_ok);  // RULE14

  // ****************************************************************
  // bus decode helpers
  // ****************************************************************
  // byte-lane merge, so a narrow write leaves the other lanes untouched
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // a write lands only once both halves are held and the last answer is gone
  // reads bypass the write slots, so a read never waits behind a write
  logic do_write;
  logic do_read;
  assign do_write = state_reg.aw_full && state_reg.w_full && !state_reg.bvalid;
  assign do_read  = s_axi_arvalid && !state_reg.rvalid;

  // ****************************************************************
  // next state
  // ****************************************************************
  // one write and one read in flight; aw and w are latched in either order
  always_comb begin
    state_next = state_reg;
    // write address and data capture
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_full = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = entry_match_pkg::resp_okay;
      case (state_reg.aw_addr)
        entry_match_pkg::ctrl_off:
          state_next.ctrl = merge(state_reg.ctrl, state_reg.w_data, state_reg.w_strb) & 32'h0000_003F;
        entry_match_pkg::flags_off:
          state_next.flags = merge(state_reg.flags, state_reg.w_data, state_reg.w_strb) & 32'h0000_0FFF;
        entry_match_pkg::src_val_off:
          state_next.src_val = merge(state_reg.src_val, state_reg.w_data, state_reg.w_strb);
        entry_match_pkg::dst_val_off:
          state_next.dst_val = merge(state_reg.dst_val, state_reg.w_data, state_reg.w_strb);
        entry_match_pkg::status_off,
        entry_match_pkg::hits_off,
        entry_match_pkg::frames_off: begin
          state_next.hits   = 32'h0000_0000;  // any write to a counter clears both
          state_next.frames = 32'h0000_0000;
        end
        default:
          state_next.bresp = entry_match_pkg::resp_slverr;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // read path answers the cycle after the address is taken
    if (do_read) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = entry_match_pkg::resp_okay;
      case (s_axi_araddr)
        entry_match_pkg::ctrl_off:    state_next.rdata = state_reg.ctrl;
        entry_match_pkg::flags_off:   state_next.rdata = state_reg.flags;
        entry_match_pkg::src_val_off: state_next.rdata = state_reg.src_val;
        entry_match_pkg::dst_val_off: state_next.rdata = state_reg.dst_val;
        entry_match_pkg::status_off:  state_next.rdata = {30'h0000_0000, state_reg.mvalid, state_reg.mhit};
        entry_match_pkg::hits_off:    state_next.rdata = state_reg.hits;
        entry_match_pkg::frames_off:  state_next.rdata = state_reg.frames;
        default: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rresp = entry_match_pkg::resp_slverr;
        end
      endcase
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    // verdict registered one cycle after the header; counters see each frame
    // counters wrap silently; software is expected to read them often enough
    state_next.mvalid = hdr_valid;  // RULE16
    state_next.mhit   = hdr_valid & entry_hit;  // RULE14
    if (hdr_valid) begin
      state_next.frames = state_next.frames + 32'h0000_0001;
      if (entry_hit) begin
        state_next.hits = state_next.hits + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // single register bank for the whole block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // protocol starts off, so nothing matches before software sets the entry
      state_reg         <= '0;
      state_reg.ctrl    <= entry_match_pkg::ctrl_rst;
      state_reg.flags   <= entry_match_pkg::flags_rst;
      state_reg.src_val <= entry_match_pkg::val_rst;
      state_reg.dst_val <= entry_match_pkg::val_rst;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // ready only while the holding slot is empty, so no beat is ever dropped
  assign s_axi_awready = !state_reg.aw_full;
  assign s_axi_wready  = !state_reg.w_full;
  // answers and verdict come straight from flops
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rresp   = state_reg.rresp;
  assign s_axi_rdata   = state_reg.rdata;
  assign match_valid   = state_reg.mvalid;
  assign match_hit     = state_reg.mhit;

endmodule

//--- entry_matcher_chk.sv
// checker: verdict timing and bus handshakes of entry_matcher
// assumes: bound to the top module, one aclk domain
`timescale 1ns/1ps
module entry_matcher_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // match path
  input wire logic        hdr_valid,
  input wire logic        match_valid,
  input wire logic        match_hit
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a verdict belongs to exactly one header, one cycle on
  match_lat_a: assert property (hdr_valid |=> match_valid)
    else $error("verdict missing after header");
  match_gap_a: assert property (!hdr_valid |=> !match_valid)
    else $error("verdict without header");
  hit_qual_a: assert property (match_hit |-> match_valid)
    else $error("hit outside verdict cycle");
  // answers hold until the master takes them
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_bound_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
endmodule
bind entry_matcher entry_matcher_chk u_entry_matcher_chk (.*);

//--- hdr_parser_model.sv
// model of the ingress parser that feeds one filter_entry
// assumes: the bench sends one header at a time
`timescale 1ns/1ps
module hdr_parser_model (
  // clock
  input wire logic              aclk,
  // header stream
  output entry_match_pkg::hdr_t hdr,
  output logic                  hdr_valid,
  // verdict seen back
  input wire logic              match_valid,
  input wire logic              match_hit
);
  // ********
  // driver
  // ********
  initial begin
    hdr_valid = 1'b0;
    hdr = '0;
  end
  // idle header shows the inverse, so a stale copy can never look valid
  task automatic send(input entry_match_pkg::hdr_t h, output logic v, output logic m);
    @(posedge aclk);
    hdr_valid <= 1'b1;
    hdr <= h;
    @(posedge aclk);
    hdr_valid <= 1'b0;
    hdr <= ~h;
    #1;
    v = match_valid;
    m = match_hit;
  endtask
endmodule

//--- entry_matcher_bench.sv
// self-checking bench of entry_matcher with an AXI4-Lite master
// assumes: package, design, checker and parser model compiled first
`timescale 1ns/1ps
module entry_matcher_bench;
  // ********
  // wiring
  // ********
  logic                  aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic                  hdr_valid, match_valid, match_hit;
  logic [7:0]            s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  entry_match_pkg::hdr_t hdr;
  int                    num_errors, tests_run;
  entry_matcher u_entry_matcher (.*);
  hdr_parser_model u_hdr_parser_model (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit got;
    got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        got = 1;
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
    if (!got) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        got = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!got) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  // p is {is_tcp, is_udp}
  task automatic frame(input logic [1:0] p, input logic [15:0] s, d, input logic [5:0] f, input logic e);
    logic v, m;
    u_hdr_parser_model.send('{p[1], p[0], s, d, f}, v, m);
    chk({31'h0, v}, 32'h0000_0001);
    chk({31'h0, m}, {31'h0, e});
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h04, d, r);
    chk(d, entry_match_pkg::flags_rst);
    rd(8'h08, d, r);
    chk(d, entry_match_pkg::val_rst);
    rd(8'h1C, d, r);
    chk({d[29:0], r}, {30'h0, entry_match_pkg::resp_slverr});
    frame(2'h1, 16'h0001, 16'h0002, 6'h00, 1'h0);
    $display("t_reset done");
  endtask
  task automatic t_ports();
    wr(8'h00, 32'h0000_0039, 2'h0);
    wr(8'h08, 32'h0000_FFFF, 2'h0);
    wr(8'h0C, 32'h0060_0050, 2'h0);
    frame(2'h1, 16'hFFFF, 16'h0050, 6'h00, 1'h1);
    frame(2'h1, 16'hFFFF, 16'h0060, 6'h00, 1'h1);
    frame(2'h1, 16'hFFFF, 16'h004F, 6'h00, 1'h0);
    frame(2'h1, 16'hFFFF, 16'h0061, 6'h00, 1'h0);
    frame(2'h1, 16'hFFFE, 16'h0055, 6'h00, 1'h0);
    wr(8'h00, 32'h0000_0034, 2'h0);
    wr(8'h0C, 32'h0000_0000, 2'h0);
    frame(2'h2, 16'h1234, 16'h0000, 6'h3F, 1'h1);
    frame(2'h1, 16'h0001, 16'h0001, 6'h00, 1'h0);
    wr(8'h00, 32'h0000_0032, 2'h0);
    wr(8'h08, 32'h0020_0010, 2'h0);
    frame(2'h1, 16'h0010, 16'hABCD, 6'h00, 1'h1);
    frame(2'h1, 16'h0021, 16'hABCD, 6'h00, 1'h0);
    wr(8'h00, 32'h0000_0033, 2'h0);
    frame(2'h1, 16'h0010, 16'hABCD, 6'h00, 1'h0);
    $display("t_ports done");
  endtask
  // each flag alone under clear and set, the rest left don't-care
  task automatic t_flags();
    logic [31:0] c;
    wr(8'h00, 32'h0000_0010, 2'h0);
    for (int k = 0; k < 6; k++) begin
      for (int s = 0; s < 2; s++) begin
        c = (32'h0000_0FFF & ~(32'h0000_0003 << (2 * k))) | (32'(s) << (2 * k));
        wr(8'h04, c, 2'h0);
        frame(2'h2, 16'h0001, 16'h0002, 6'h01 << k, s[0]);
        frame(2'h2, 16'h0001, 16'h0002, ~(6'h01 << k), !s[0]);
      end
    end
    // reserved code on the first flag never matches
    wr(8'h04, 32'h0000_0FFE, 2'h0);
    frame(2'h2, 16'h0001, 16'h0002, 6'h00, 1'h0);
    frame(2'h2, 16'h0001, 16'h0002, 6'h01, 1'h0);
    frame(2'h1, 16'h0001, 16'h0002, 6'h00, 1'h0);
    wr(8'h00, 32'h0000_0030, 2'h0);
    wr(8'h04, 32'h0000_0000, 2'h0);
    frame(2'h1, 16'h0001, 16'h0002, 6'h3F, 1'h1);
    frame(2'h2, 16'h0001, 16'h0002, 6'h3F, 1'h0);
    $display("t_flags done");
  endtask
  task automatic t_counts();
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h14, 32'h0000_0000, 2'h0);
    frame(2'h1, 16'h0001, 16'h0002, 6'h3F, 1'h1);
    frame(2'h2, 16'h0001, 16'h0002, 6'h3F, 1'h0);
    rd(8'h18, d, r);
    chk(d, 32'h0000_0002);
    rd(8'h14, d, r);
    chk(d, 32'h0000_0001);
    wr(8'h18, 32'h0000_0000, 2'h0);
    rd(8'h18, d, r);
    chk(d, 32'h0000_0000);
    rd(8'h10, d, r);
    chk({d[29:0], r}, {30'h0, entry_match_pkg::resp_okay});
    wr(8'h1C, 32'h0000_FFFF, entry_match_pkg::resp_slverr);
    // one byte lane only: upper bytes of the source value must survive
    s_axi_wstrb <= 4'h1;
    wr(8'h08, 32'hFFFF_FF55, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h08, d, r);
    chk(d, 32'h0020_0055);
    rd(8'h00, d, r);
    chk(d, 32'h0000_0030);
    $display("t_counts done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ********
  // sequence and watchdog
  // ********
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ports();
    t_flags();
    t_counts();
    final_report();
  end
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
